// ---- hdl/ofbs_pkg.sv ----
// Shared constants, states and carrier structs of the scan-wrapped octal flop.
// Assumes one four-wire test access port and eight data paths.
package ofbs_pkg;

    localparam int DATA_W = 8;
    localparam int IR_W = 8;
    localparam int BSR_W = 18;
    localparam int BCR_W = 2;

    // Boundary cell positions, lowest cell nearest the serial output
    localparam int BSR_Q_LSB = 0;
    localparam int BSR_D_LSB = 8;
    localparam int BSR_CLK = 16;
    localparam int BSR_OE = 17;

    localparam logic [7:0] IR_RESET = 8'hFF;
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [1:0] BCR_RESET = 2'h2;

    localparam logic [7:0] OP_EXTEST = 8'h00;
    localparam logic [7:0] OP_SAMPLE = 8'h02;
    localparam logic [7:0] OP_INTEST = 8'h03;
    localparam logic [7:0] OP_HIGHZ = 8'h06;
    localparam logic [7:0] OP_CLAMP = 8'h07;
    localparam logic [7:0] OP_RUNT = 8'h09;
    localparam logic [7:0] OP_SCANCT = 8'h0E;
    localparam logic [7:0] OP_BYPASS = 8'hFF;

    // Boundary-control operations, run in idle under OP_RUNT
    localparam logic [1:0] BC_TOGGLE = 2'h0;
    localparam logic [1:0] BC_PATTERN = 2'h1;
    localparam logic [1:0] BC_SIGNATURE = 2'h2;
    localparam logic [1:0] BC_BOTH = 2'h3;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } ofbs_tap_e;

    // Pin snapshot, laid out exactly as the boundary register
    typedef struct packed {
        logic oe_n;
        logic clk;
        logic [7:0] d;
        logic [7:0] q;
    } ofbs_pins_s;

    // Mode word crossing from the test clock to the core clock
    typedef struct packed {
        logic test;
        logic highz;
        logic intest;
        logic tog;
    } ofbs_ctl_s;

    typedef struct packed {
        ofbs_tap_e state;
        logic [7:0] ir_sh;
        logic [17:0] bsr_sh;
        logic [1:0] bcr_sh;
        logic byp;
    } ofbs_tap_s;

    typedef struct packed {
        logic [7:0] ir;
        logic [17:0] upd;
        logic [1:0] bcr;
        ofbs_ctl_s ctl;
        logic tdo;
        logic tdo_oe_n;
    } ofbs_neg_s;

    typedef struct packed {
        logic clk_prev;
        logic tog_prev;
        logic [17:0] word;
        logic [7:0] q;
        logic [7:0] out;
        logic oe_n;
    } ofbs_core_s;

    localparam ofbs_tap_s TAP_RESET = '{state: TLR, ir_sh: 8'h00, bsr_sh: 18'h00000, bcr_sh: 2'h0, byp: 1'b0};
    localparam ofbs_neg_s NEG_RESET = '{ir: IR_RESET, upd: 18'h00000, bcr: BCR_RESET,
        ctl: 4'h0, tdo: 1'b0, tdo_oe_n: 1'b1};
    localparam ofbs_core_s CORE_RESET = '{clk_prev: 1'b0, tog_prev: 1'b0, word: 18'h00000,
        q: 8'h00, out: 8'h00, oe_n: 1'b1};

    // Zero state reseeds to one so the generator never locks up
    function automatic logic [7:0] ofbs_lfsr(input logic [7:0] s);
        return {s[6:0], (s[7] ^ s[5] ^ s[4] ^ s[3]) | ~|s};
    endfunction

endpackage

// ---- hdl/ofbs_sync.sv ----
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a level; multi-bit words need their own crossing.
`timescale 1ns/1ps
module ofbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ofbs_sync_s;

    ofbs_sync_s st;
    ofbs_sync_s next_st;

    always_comb
    begin
        next_st.meta = d;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign q = st.stable;
endmodule

// ---- hdl/ofbs_top.sv ----
// Octal edge-triggered flop with boundary-scan test logic on a four-wire port.
// Assumes core_clk is free running; tck comes from the scan controller.
//
// Summary of operation
// R1: Normal mode: flops load data on clock rise
// R2: Port activity in normal mode leaves flops alone
// R3: Test mode inhibits flops, test logic controls boundary
// R4: Snapshot pin values and self-test boundary cells
// R5: Sample on test clock rise, drive on fall
// R6: Serial input feeds selected shift path
// R7: Serial output drives while shifting, else off
// R8: Controller moves only by sampled mode select
// R9: Double-high level asynchronously resets test logic
// R10: Test control comes only from clock and select
// R11: Instruction register is eight bits long
// R12: Eighteen-bit boundary, two-bit control, one-bit bypass
// R13: Mandatory instructions plus INTEST, CLAMP, HIGHZ
// R14: Input signature compaction, output pattern generation
// R15: Sample inputs while toggling outputs
// R16: Reset loads all-ones instruction, control pattern 10
// R17: Instruction capture loads fixed status 10000001
// R18: Select held high reaches reset within five
// R19: Control operations run only in idle
// R20: Test mode drives outputs from update latches
// R21: Normal clock and test clock are independent
`timescale 1ns/1ps
module ofbs_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic flop_clk,
    input wire logic drive_enable_low,
    input wire logic [7:0] flop_data_inputs,
    output logic [7:0] flop_data_outputs,
    output logic flop_data_oe_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tms_double_high,
    output logic tdo,
    output logic tdo_oe_n
);
    ofbs_pkg::ofbs_tap_s ts;
    ofbs_pkg::ofbs_tap_s next_ts;
    ofbs_pkg::ofbs_neg_s tn;
    ofbs_pkg::ofbs_neg_s next_tn;
    ofbs_pkg::ofbs_core_s cs;
    ofbs_pkg::ofbs_core_s next_cs;
    ofbs_pkg::ofbs_pins_s pin_t;
    ofbs_pkg::ofbs_pins_s pin_raw;
    ofbs_pkg::ofbs_ctl_s ctl_c;
    logic [9:0] pin_c;
    logic pin_c_oe_n;
    logic pin_c_clk;
    logic [7:0] pin_c_d;
    logic tap_rst;
    logic sel_bsr;
    logic sel_bcr;
    logic sel_byp;
    logic runt;
    logic tog_ev;

    // Power-up reset or the double-high level on mode select
    assign tap_rst = reset | tms_double_high; // R9

    // Pin snapshot into the test clock domain
    assign pin_raw = '{oe_n: drive_enable_low, clk: flop_clk, d: flop_data_inputs, q: cs.out};

    ofbs_sync #(
        .WIDTH(ofbs_pkg::BSR_W)
    ) u_sync_tck (
        .clk(tck),
        .d(pin_raw),
        .q(pin_t)
    ); // R21

    // Pins and test mode into the core clock domain
    ofbs_sync #(
        .WIDTH(14)
    ) u_sync_core (
        .clk(core_clk),
        .d({drive_enable_low, flop_clk, flop_data_inputs, tn.ctl}),
        .q({pin_c, ctl_c})
    ); // R21

    assign pin_c_oe_n = pin_c[9];
    assign pin_c_clk = pin_c[8];
    assign pin_c_d = pin_c[7:0];

    // Data register selection from the active instruction
    always_comb
    begin
        sel_bsr = (tn.ir == ofbs_pkg::OP_EXTEST) || (tn.ir == ofbs_pkg::OP_SAMPLE)
            || (tn.ir == ofbs_pkg::OP_INTEST); // R13
        sel_bcr = (tn.ir == ofbs_pkg::OP_SCANCT); // R12
        sel_byp = !sel_bsr && !sel_bcr; // R12
        runt = (tn.ir == ofbs_pkg::OP_RUNT);
    end

    function automatic ofbs_pkg::ofbs_tap_e tap_next(input ofbs_pkg::ofbs_tap_e s, input logic m);
        unique case (s)
            ofbs_pkg::TLR: return m ? ofbs_pkg::TLR : ofbs_pkg::RTI;
            ofbs_pkg::RTI: return m ? ofbs_pkg::SEL_DR : ofbs_pkg::RTI;
            ofbs_pkg::SEL_DR: return m ? ofbs_pkg::SEL_IR : ofbs_pkg::CAP_DR;
            ofbs_pkg::CAP_DR: return m ? ofbs_pkg::EXIT1_DR : ofbs_pkg::SHIFT_DR;
            ofbs_pkg::SHIFT_DR: return m ? ofbs_pkg::EXIT1_DR : ofbs_pkg::SHIFT_DR;
            ofbs_pkg::EXIT1_DR: return m ? ofbs_pkg::UPD_DR : ofbs_pkg::PAUSE_DR;
            ofbs_pkg::PAUSE_DR: return m ? ofbs_pkg::EXIT2_DR : ofbs_pkg::PAUSE_DR;
            ofbs_pkg::EXIT2_DR: return m ? ofbs_pkg::UPD_DR : ofbs_pkg::SHIFT_DR;
            ofbs_pkg::UPD_DR: return m ? ofbs_pkg::SEL_DR : ofbs_pkg::RTI;
            ofbs_pkg::SEL_IR: return m ? ofbs_pkg::TLR : ofbs_pkg::CAP_IR;
            ofbs_pkg::CAP_IR: return m ? ofbs_pkg::EXIT1_IR : ofbs_pkg::SHIFT_IR;
            ofbs_pkg::SHIFT_IR: return m ? ofbs_pkg::EXIT1_IR : ofbs_pkg::SHIFT_IR;
            ofbs_pkg::EXIT1_IR: return m ? ofbs_pkg::UPD_IR : ofbs_pkg::PAUSE_IR;
            ofbs_pkg::PAUSE_IR: return m ? ofbs_pkg::EXIT2_IR : ofbs_pkg::PAUSE_IR;
            ofbs_pkg::EXIT2_IR: return m ? ofbs_pkg::UPD_IR : ofbs_pkg::SHIFT_IR;
            ofbs_pkg::UPD_IR: return m ? ofbs_pkg::SEL_DR : ofbs_pkg::RTI;
        endcase
    endfunction

    // Rising-edge half: state, capture and shift
    always_comb
    begin
        next_ts = ts;
        next_ts.state = tap_next(ts.state, tms); // R8 R10 R18
        if (ts.state == ofbs_pkg::CAP_IR)
        begin
            next_ts.ir_sh = ofbs_pkg::IR_CAPTURE; // R17
        end
        if (ts.state == ofbs_pkg::SHIFT_IR)
        begin
            next_ts.ir_sh = {tdi, ts.ir_sh[7:1]}; // R6 R11
        end
        if (ts.state == ofbs_pkg::CAP_DR)
        begin
            if (sel_bsr)
            begin
                next_ts.bsr_sh = pin_t; // R4
            end
            if (sel_bcr)
            begin
                next_ts.bcr_sh = tn.bcr;
            end
            if (sel_byp)
            begin
                next_ts.byp = 1'b0;
            end
        end
        if (ts.state == ofbs_pkg::SHIFT_DR)
        begin
            if (sel_bsr)
            begin
                next_ts.bsr_sh = {tdi, ts.bsr_sh[17:1]}; // R6
            end
            else if (sel_bcr)
            begin
                next_ts.bcr_sh = {tdi, ts.bcr_sh[1]}; // R6
            end
            else
            begin
                next_ts.byp = tdi; // R6
            end
        end
        // Input cells compact or sample only while idling
        if (ts.state == ofbs_pkg::RTI && runt) // R19
        begin
            if (tn.bcr == ofbs_pkg::BC_SIGNATURE || tn.bcr == ofbs_pkg::BC_BOTH)
            begin
                next_ts.bsr_sh[15:8] = ofbs_pkg::ofbs_lfsr(ts.bsr_sh[15:8]) ^ pin_t.d; // R14
            end
            else if (tn.bcr == ofbs_pkg::BC_TOGGLE)
            begin
                next_ts.bsr_sh[15:8] = pin_t.d; // R15
            end
        end
    end

    always_ff @(posedge tck or posedge tap_rst) // R5 R9
    begin
        if (tap_rst)
        begin
            ts <= ofbs_pkg::TAP_RESET;
        end
        else
        begin
            ts <= next_ts;
        end
    end

    // Falling-edge half: updates, output patterns and serial output
    always_comb
    begin
        next_tn = tn;
        if (ts.state == ofbs_pkg::TLR)
        begin
            next_tn.ir = ofbs_pkg::IR_RESET; // R16
            next_tn.bcr = ofbs_pkg::BCR_RESET; // R16
        end
        if (ts.state == ofbs_pkg::UPD_IR)
        begin
            next_tn.ir = ts.ir_sh; // R11
        end
        if (ts.state == ofbs_pkg::UPD_DR && sel_bsr)
        begin
            next_tn.upd = ts.bsr_sh; // R4
        end
        if (ts.state == ofbs_pkg::UPD_DR && sel_bcr)
        begin
            next_tn.bcr = ts.bcr_sh;
        end
        if (ts.state == ofbs_pkg::RTI && runt) // R19
        begin
            if (tn.bcr == ofbs_pkg::BC_PATTERN || tn.bcr == ofbs_pkg::BC_BOTH)
            begin
                next_tn.upd[7:0] = ofbs_pkg::ofbs_lfsr(tn.upd[7:0]); // R14
            end
            else if (tn.bcr == ofbs_pkg::BC_TOGGLE)
            begin
                next_tn.upd[7:0] = ~tn.upd[7:0]; // R15
            end
        end
        // Mode decode is registered so the crossing never sees a glitch
        next_tn.ctl.test = (next_tn.ir == ofbs_pkg::OP_EXTEST) || (next_tn.ir == ofbs_pkg::OP_INTEST)
            || (next_tn.ir == ofbs_pkg::OP_HIGHZ) || (next_tn.ir == ofbs_pkg::OP_CLAMP)
            || (next_tn.ir == ofbs_pkg::OP_RUNT); // R2 R3 R13
        next_tn.ctl.highz = (next_tn.ir == ofbs_pkg::OP_HIGHZ); // R13
        next_tn.ctl.intest = (next_tn.ir == ofbs_pkg::OP_INTEST); // R13
        next_tn.ctl.tog = tn.ctl.tog ^ (next_tn.upd != tn.upd);
        next_tn.tdo_oe_n = 1'b1; // R7
        if (ts.state == ofbs_pkg::SHIFT_IR)
        begin
            next_tn.tdo = ts.ir_sh[0]; // R7
            next_tn.tdo_oe_n = 1'b0;
        end
        else if (ts.state == ofbs_pkg::SHIFT_DR)
        begin
            next_tn.tdo = sel_bsr ? ts.bsr_sh[0] : (sel_bcr ? ts.bcr_sh[0] : ts.byp); // R7
            next_tn.tdo_oe_n = 1'b0;
        end
    end

    always_ff @(negedge tck or posedge tap_rst) // R5 R9
    begin
        if (tap_rst)
        begin
            tn <= ofbs_pkg::NEG_RESET;
        end
        else
        begin
            tn <= next_tn;
        end
    end

    // Update word changes with each toggle and then holds for a whole test clock
    assign tog_ev = ctl_c.tog != cs.tog_prev;

    always_comb
    begin
        next_cs = cs;
        next_cs.clk_prev = pin_c_clk;
        next_cs.tog_prev = ctl_c.tog;
        if (tog_ev)
        begin
            next_cs.word = tn.upd;
        end
        if (!ctl_c.test)
        begin
            if (pin_c_clk && !cs.clk_prev)
            begin
                next_cs.q = pin_c_d; // R1 R2
            end
            next_cs.out = next_cs.q; // R1
            next_cs.oe_n = pin_c_oe_n; // R1
        end
        else
        begin
            // Internal flop clocked only from the boundary cells
            if (ctl_c.intest && tog_ev && tn.upd[ofbs_pkg::BSR_CLK] && !cs.word[ofbs_pkg::BSR_CLK])
            begin
                next_cs.q = tn.upd[15:8]; // R3
            end
            next_cs.out = next_cs.word[7:0]; // R20
            next_cs.oe_n = ctl_c.highz | next_cs.word[ofbs_pkg::BSR_OE]; // R3 R13
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cs <= ofbs_pkg::CORE_RESET;
        end
        else
        begin
            cs <= next_cs;
        end
    end

    assign flop_data_outputs = cs.out;
    assign flop_data_oe_n = cs.oe_n;
    assign tdo = tn.tdo;
    assign tdo_oe_n = tn.tdo_oe_n;

    property p_normal_load;
        @(posedge core_clk) disable iff (reset)
        !ctl_c.test && pin_c_clk && !cs.clk_prev |=> flop_data_outputs == $past(pin_c_d);
    endproperty
    a_normal_load: assert property (p_normal_load) else $error("normal flop missed load"); // R1

    property p_oe_follow;
        @(posedge core_clk) disable iff (reset)
        !ctl_c.test |=> flop_data_oe_n == $past(pin_c_oe_n);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("output enable not followed"); // R1

    property p_test_hold;
        @(posedge core_clk) disable iff (reset)
        ctl_c.test && !ctl_c.intest |=> cs.q == $past(cs.q);
    endproperty
    a_test_hold: assert property (p_test_hold) else $error("flop changed in test mode"); // R3

    property p_out_upd;
        @(posedge core_clk) disable iff (reset)
        ctl_c.test && tog_ev |=> flop_data_outputs == $past(tn.upd[7:0]);
    endproperty
    a_out_upd: assert property (p_out_upd) else $error("output not from update latch"); // R20

    property p_highz;
        @(posedge core_clk) disable iff (reset)
        ctl_c.test && ctl_c.highz |=> flop_data_oe_n;
    endproperty
    a_highz: assert property (p_highz) else $error("output driven under high impedance"); // R3

    property p_tlr;
        @(posedge tck) disable iff (tap_rst)
        tms [*5] |=> ts.state == ofbs_pkg::TLR;
    endproperty
    a_tlr: assert property (p_tlr) else $error("no reset after five high selects"); // R18

    // Test clock is usually stopped while the level is applied
    property p_dhigh;
        @(posedge core_clk) disable iff (reset)
        tms_double_high |-> ts.state == ofbs_pkg::TLR && tn.ir == ofbs_pkg::IR_RESET;
    endproperty
    a_dhigh: assert property (p_dhigh) else $error("double high did not reset"); // R9

    property p_rti_hold;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::RTI && !tms |=> ts.state == ofbs_pkg::RTI;
    endproperty
    a_rti_hold: assert property (p_rti_hold) else $error("left idle with select low"); // R8

    property p_capir;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::CAP_IR |=> ts.ir_sh == ofbs_pkg::IR_CAPTURE;
    endproperty
    a_capir: assert property (p_capir) else $error("wrong instruction capture"); // R17

    property p_shift_ir;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::SHIFT_IR |=> ts.ir_sh == {$past(tdi), $past(ts.ir_sh[7:1])};
    endproperty
    a_shift_ir: assert property (p_shift_ir) else $error("instruction shift wrong"); // R6

    property p_tdo_on;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::SHIFT_IR |-> !tdo_oe_n && tdo == ts.ir_sh[0];
    endproperty
    a_tdo_on: assert property (p_tdo_on) else $error("serial output not driven"); // R7

    property p_tdo_off;
        @(posedge tck) disable iff (tap_rst)
        ts.state != ofbs_pkg::SHIFT_IR && ts.state != ofbs_pkg::SHIFT_DR |-> tdo_oe_n;
    endproperty
    a_tdo_off: assert property (p_tdo_off) else $error("serial output driven outside shift"); // R7

    property p_tlr_regs;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::TLR |=> tn.ir == ofbs_pkg::IR_RESET && tn.bcr == ofbs_pkg::BCR_RESET;
    endproperty
    a_tlr_regs: assert property (p_tlr_regs) else $error("reset values not loaded"); // R16

    property p_bypass;
        @(posedge tck) disable iff (tap_rst)
        ts.state == ofbs_pkg::SHIFT_DR && sel_byp ##1 ts.state == ofbs_pkg::SHIFT_DR |-> tdo == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not one bit"); // R12

    c_upd_ir: cover property (@(posedge tck) disable iff (tap_rst) ts.state == ofbs_pkg::UPD_IR);
    c_upd_bsr: cover property (@(posedge tck) disable iff (tap_rst) ts.state == ofbs_pkg::UPD_DR && sel_bsr);
    c_runt: cover property (@(posedge tck) disable iff (tap_rst) ts.state == ofbs_pkg::RTI && runt);
    c_test: cover property (@(posedge core_clk) disable iff (reset) ctl_c.test && tog_ev);
endmodule

// ---- verif/ofbs_scan_ctrl.sv ----
// Behavioural scan controller standing on the far side of the test port.
// Assumes tck idles low between frames and the tdo line has a pull-up.
`timescale 1ns/1ps
module ofbs_scan_ctrl (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic tdo_line;

    // Released line floats to the pull-up level
    assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock: move after the fall, sample tdo at the rise
    task automatic step(input logic m, input logic d, output logic o);
    begin
        tms = m;
        tdi = d;
        #77;
        tck = 1'b1;
        o = tdo_line;
        #80;
        tck = 1'b0;
        #3;
    end
    endtask

    // Idle data toggles so a stale bit never looks valid
    task automatic goto_idle();
        logic o;
    begin
        repeat (5) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    end
    endtask

    // Full scan from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [17:0] din, output logic [17:0] dout);
        logic o;
    begin
        dout = 18'h00000;
        step(1'b1, ~tdi, o);
        if (ir)
            step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    end
    endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the scan-wrapped octal flop.
// Assumes the scan controller model drives the test port.
`timescale 1ns/1ps
module testbench;
    logic core_clk, reset, flop_clk, drive_enable_low, tms_double_high;
    logic [7:0] flop_data_inputs;
    logic [7:0] flop_data_outputs;
    logic flop_data_oe_n, tck, tms, tdi, tdo, tdo_oe_n;
    logic [17:0] dout;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    ofbs_top ofbs_top_i (
        .core_clk(core_clk),
        .reset(reset),
        .flop_clk(flop_clk),
        .drive_enable_low(drive_enable_low),
        .flop_data_inputs(flop_data_inputs),
        .flop_data_outputs(flop_data_outputs),
        .flop_data_oe_n(flop_data_oe_n),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tms_double_high(tms_double_high),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n)
    );

    ofbs_scan_ctrl ofbs_scan_ctrl_i (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic wrap_up();
    begin
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // Whole run needs a few thousand core cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    begin
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    // Pin paths are synchronised, so allow the crossing to settle
    task automatic wait_core(input int n);
    begin
        repeat (n) @(posedge core_clk);
        #1;
    end
    endtask

    task automatic set_pins(input logic en_n, input logic [7:0] d);
    begin
        @(posedge core_clk);
        #1;
        drive_enable_low = en_n;
        flop_data_inputs = d;
    end
    endtask

    task automatic pulse_clk();
    begin
        @(posedge core_clk);
        #1;
        flop_clk = 1'b1;
        wait_core(8);
        flop_clk = 1'b0;
        wait_core(8);
    end
    endtask

    task automatic load_ir(input logic [7:0] op);
    begin
        ofbs_scan_ctrl_i.scan(1'b1, 8, {10'h000, op}, dout);
        chk("ir capture", 18'h00081, dout);
        wait_core(12);
    end
    endtask

    task automatic t_reset_state();
    begin
        chk("tdo_oe_n idle", 18'h00001, {17'h0, tdo_oe_n});
        ofbs_scan_ctrl_i.scan(1'b0, 2, 18'h00001, dout);
        chk("bypass after reset", 18'h00002, dout);
        load_ir(ofbs_pkg::OP_SCANCT);
        ofbs_scan_ctrl_i.scan(1'b0, 2, 18'h00002, dout);
        chk("control after reset", {16'h0, ofbs_pkg::BCR_RESET}, dout);
    end
    endtask

    task automatic t_normal();
    begin
        set_pins(1'b0, 8'hA5);
        pulse_clk();
        chk("outputs load", 18'h000A5, {10'h0, flop_data_outputs});
        chk("oe_n driven", 18'h00000, {17'h0, flop_data_oe_n});
        set_pins(1'b0, 8'h5A);
        ofbs_scan_ctrl_i.scan(1'b0, 2, 18'h00003, dout);
        wait_core(12);
        chk("outputs hold", 18'h000A5, {10'h0, flop_data_outputs});
        pulse_clk();
        chk("outputs reload", 18'h0005A, {10'h0, flop_data_outputs});
        set_pins(1'b1, 8'h5A);
        wait_core(12);
        chk("oe_n released", 18'h00001, {17'h0, flop_data_oe_n});
    end
    endtask

    task automatic t_sample();
    begin
        set_pins(1'b0, 8'h3C);
        load_ir(ofbs_pkg::OP_SAMPLE);
        ofbs_scan_ctrl_i.scan(1'b0, 18, 18'h00000, dout);
        chk("pin snapshot", {1'b0, 1'b0, 8'h3C, 8'h5A}, dout);
    end
    endtask

    task automatic t_extest();
    begin
        load_ir(ofbs_pkg::OP_EXTEST);
        ofbs_scan_ctrl_i.scan(1'b0, 18, {2'b00, 8'h00, 8'hC3}, dout);
        wait_core(12);
        chk("extest outputs", 18'h000C3, {10'h0, flop_data_outputs});
        pulse_clk();
        chk("flop inhibited", 18'h000C3, {10'h0, flop_data_outputs});
        load_ir(ofbs_pkg::OP_HIGHZ);
        chk("highz oe_n", 18'h00001, {17'h0, flop_data_oe_n});
    end
    endtask

    task automatic t_test_reset();
        logic o;
    begin
        ofbs_scan_ctrl_i.goto_idle();
        wait_core(12);
        chk("normal after tms reset", 18'h0005A, {10'h0, flop_data_outputs});
        chk("oe_n after tms reset", 18'h00000, {17'h0, flop_data_oe_n});
        load_ir(ofbs_pkg::OP_HIGHZ);
        @(posedge core_clk);
        #1;
        tms_double_high = 1'b1;
        wait_core(4);
        tms_double_high = 1'b0;
        ofbs_scan_ctrl_i.step(1'b0, 1'b0, o);
        wait_core(12);
        chk("oe_n after double high", 18'h00000, {17'h0, flop_data_oe_n});
        ofbs_scan_ctrl_i.scan(1'b0, 2, 18'h00001, dout);
        chk("bypass after double high", 18'h00002, dout);
    end
    endtask

    task automatic t_clamp_runt();
        logic o;
    begin
        load_ir(ofbs_pkg::OP_SAMPLE);
        ofbs_scan_ctrl_i.scan(1'b0, 18, {2'b00, 8'h00, 8'h96}, dout);
        wait_core(12);
        chk("preload in normal mode", 18'h0005A, {10'h0, flop_data_outputs});
        load_ir(ofbs_pkg::OP_CLAMP);
        chk("clamp outputs", 18'h00096, {10'h0, flop_data_outputs});
        load_ir(ofbs_pkg::OP_SCANCT);
        ofbs_scan_ctrl_i.scan(1'b0, 2, {16'h0, ofbs_pkg::BC_TOGGLE}, dout);
        chk("control after double high", {16'h0, ofbs_pkg::BCR_RESET}, dout);
        load_ir(ofbs_pkg::OP_RUNT);
        chk("toggle on idle entry", 18'h00069, {10'h0, flop_data_outputs});
        ofbs_scan_ctrl_i.step(1'b0, 1'b0, o);
        wait_core(12);
        chk("toggle per idle cycle", 18'h00096, {10'h0, flop_data_outputs});
        // Six falls, one in idle: an odd count only if idle alone toggles
        ofbs_scan_ctrl_i.scan(1'b0, 1, 18'h00000, dout);
        wait_core(12);
        chk("toggle only in idle", 18'h00069, {10'h0, flop_data_outputs});
        load_ir(ofbs_pkg::OP_SCANCT);
        ofbs_scan_ctrl_i.scan(1'b0, 2, {16'h0, ofbs_pkg::BC_PATTERN}, dout);
        load_ir(ofbs_pkg::OP_RUNT);
        chk("pattern step", 18'h000D2, {10'h0, flop_data_outputs});
        ofbs_scan_ctrl_i.goto_idle();
        wait_core(12);
        chk("flop held through test", 18'h0005A, {10'h0, flop_data_outputs});
    end
    endtask

    initial
    begin
        reset = 1'b1;
        flop_clk = 1'b0;
        drive_enable_low = 1'b1;
        flop_data_inputs = 8'h00;
        tms_double_high = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        reset = 1'b0;
        wait_core(4);
        ofbs_scan_ctrl_i.goto_idle();
        t_reset_state();
        t_normal();
        t_sample();
        t_extest();
        t_test_reset();
        t_clamp_runt();
        wrap_up();
    end
endmodule
